// >>> rtl/sgs_gain_switch.sv
// sgs_gain_switch: picks before or after loop parameter set and smooths the change
// assumes a single-cycle strobe register port and monitored quantities on clk_sys
//
// Functional notes
// [RL1] Active position, speed, integral and inertia follow the condition and threshold.
// [RL2] Switching only in manual tuning mode; otherwise the before set is used.
// [RL3] Model loop gain is always valid and never switched.
// [RL4] Condition decoded from lowest and second-lowest selection digits.
// [RL5] Lowest digit 1 follows the external gain switch input bit.
// [RL6] Command frequency, droop or speed compared against the threshold setting.
// [RL7] Each switched value passes a first-order lag with the set time constant.
// [RL8] After condition uses after-change position, speed and integral settings.
// [RL9] After condition uses after-change inertia and vibration frequency settings.
// [RL10] Software should set after inertia equal to before when load is unchanged.
// [RL11] Selection 0001 switches on both edges of the input, each filtered.
// [RL12] Selection 0003 switches on droop pulse count against the threshold.
// [RL13] When the condition ends every value returns through the same filter.
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none

module sgs_gain_switch
  import sgs_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = STEP_CYC
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  // register port
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic      [DW-1:0] rdata,
  // monitored quantities
  input  wire logic          external_gain_switch_input,
  input  wire logic [DW-1:0] command_freq,
  input  wire logic [DW-1:0] droop_pulses,
  input  wire logic [DW-1:0] motor_speed,
  // loop parameters
  output logic      [DW-1:0] model_loop_gain,
  output logic      [DW-1:0] inertia_ratio_out,
  output logic      [DW-1:0] position_gain_out,
  output logic      [DW-1:0] speed_gain_out,
  output logic      [DW-1:0] speed_integral_out,
  output logic      [DW-1:0] vib_freq_out,
  output logic      [DW-1:0] resonance_freq_out,
  output logic               gain_after_active
);

  localparam int unsigned PW = 32;

  // parameter storage
  logic [DW-1:0] before_set [N_CHAN];
  logic [DW-1:0] after_set  [N_CHAN];
  logic [DW-1:0] switch_condition_select;
  logic [DW-1:0] switch_threshold;
  logic [DW-1:0] switch_time_constant;
  logic [DW-1:0] tuning_mode_setting;

  // external input synchroniser
  logic ext_meta;
  logic ext_sync;

  // condition decode
  logic [3:0]    sel_lo;
  logic [3:0]    sel_hi;
  logic          switching_enabled;
  logic [DW-1:0] cond_qty;
  logic          qty_at_level;
  logic          cond_raw;
  logic          cond_valid;
  logic          next_after;

  // filter pacing
  logic [PW-1:0] step_len;
  logic [PW-1:0] step_cnt;
  logic          step_pulse;
  logic          primed;
  logic          lag_bypass;

  // filter data
  logic [DW-1:0] target [N_CHAN];
  logic [DW-1:0] filt   [N_CHAN];

  // register access decode
  logic          wr_before;
  logic          wr_after;
  logic [2:0]    wr_idx;
  logic [DW-1:0] status_word;
  logic [DW-1:0] read_mux;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end else begin
      ext_meta <= external_gain_switch_input;
      ext_sync <= ext_meta;
    end
  end

  assign sel_lo            = switch_condition_select[3:0];
  assign sel_hi            = switch_condition_select[7:4];
  assign switching_enabled = (tuning_mode_setting[3:0] == TUNE_MANUAL); // see [RL2]

  assign cond_qty     = (sel_lo == SGS_COND_CMD)   ? command_freq :
                        (sel_lo == SGS_COND_DROOP) ? droop_pulses : motor_speed;
  assign qty_at_level = (cond_qty >= switch_threshold); // see [RL6]

  // lowest digit picks the source; second digit 1 inverts the sense
  assign cond_valid = (sel_lo == SGS_COND_EXT) || (sel_lo == SGS_COND_CMD) ||
                      (sel_lo == SGS_COND_DROOP) || (sel_lo == SGS_COND_SPEED); // see [RL4]
  assign cond_raw   = (sel_lo == SGS_COND_EXT) ? ext_sync : qty_at_level; // see [RL5] [RL12]
  assign next_after = switching_enabled && cond_valid && (cond_raw ^ sel_hi[0]); // see [RL1]

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      gain_after_active <= 1'b0;
    end else begin
      gain_after_active <= next_after; // see [RL11] [RL13]
    end
  end

  // step period scales with the time constant; 2^LAG_SHIFT steps make one constant
  assign step_len   = PW'(switch_time_constant) * PW'(STEP_CYCLES);
  assign lag_bypass = !primed || (switch_time_constant == '0);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      step_cnt   <= '0;
      step_pulse <= 1'b0;
      primed     <= 1'b0;
    end else begin
      primed <= 1'b1;
      if (lag_bypass || (step_cnt + 1'b1 >= step_len)) begin
        step_cnt   <= '0;
        step_pulse <= !lag_bypass;
      end else begin
        step_cnt   <= step_cnt + 1'b1;
        step_pulse <= 1'b0;
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < N_CHAN; ch++) begin : g_chan
      assign target[ch] = gain_after_active ? after_set[ch] : before_set[ch]; // see [RL8] [RL9]

      sgs_lag_filter #(
        .W (DW),
        .F (LAG_SHIFT)
      ) u_lag (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .step    (step_pulse),
        .bypass  (lag_bypass),
        .target  (target[ch]),
        .value   (filt[ch])
      ); // see [RL7] [RL13]
    end
  endgenerate

  assign inertia_ratio_out  = filt[CH_INERTIA];
  assign position_gain_out  = filt[CH_POS_GAIN];
  assign speed_gain_out     = filt[CH_SPD_GAIN];
  assign speed_integral_out = filt[CH_SPD_INT];
  assign vib_freq_out       = filt[CH_VIB_FREQ];
  assign resonance_freq_out = filt[CH_RES_FREQ];

  // register writes
  assign wr_before = wr && (addr >= ADDR_BEFORE_BASE) && (addr < ADDR_BEFORE_BASE + N_CHAN);
  assign wr_after  = wr && (addr >= ADDR_AFTER_BASE) && (addr < ADDR_AFTER_BASE + N_CHAN);
  assign wr_idx    = addr[2:0];

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int i = 0; i < N_CHAN; i++) begin
        before_set[i] <= RST_BEFORE[i];
        after_set[i]  <= RST_AFTER[i];
      end
    end else begin
      if (wr_before) begin
        before_set[wr_idx] <= wdata;
      end
      if (wr_after) begin
        after_set[wr_idx] <= wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      model_loop_gain         <= RST_MODEL_GAIN;
      switch_condition_select <= RST_COND_SELECT;
      switch_threshold        <= RST_THRESHOLD;
      switch_time_constant    <= RST_TIME_CONST;
      tuning_mode_setting     <= RST_TUNING_MODE;
    end else if (wr) begin
      unique case (addr)
        ADDR_MODEL_GAIN:  model_loop_gain         <= wdata; // see [RL3]
        ADDR_COND_SELECT: switch_condition_select <= wdata;
        ADDR_THRESHOLD:   switch_threshold        <= wdata;
        ADDR_TIME_CONST:  switch_time_constant    <= wdata;
        ADDR_TUNING_MODE: tuning_mode_setting     <= wdata;
        default: ;
      endcase
    end
  end

  // register reads: data stand one cycle after the strobe, unmapped reads zero
  assign status_word = {13'h0000, ext_sync, switching_enabled, gain_after_active};
  assign read_mux =
    (addr >= ADDR_BEFORE_BASE && addr < ADDR_BEFORE_BASE + N_CHAN) ? before_set[addr[2:0]] :
    (addr >= ADDR_AFTER_BASE && addr < ADDR_AFTER_BASE + N_CHAN)   ? after_set[addr[2:0]]  :
    (addr == ADDR_MODEL_GAIN)  ? model_loop_gain         :
    (addr == ADDR_COND_SELECT) ? switch_condition_select :
    (addr == ADDR_THRESHOLD)   ? switch_threshold        :
    (addr == ADDR_TIME_CONST)  ? switch_time_constant    :
    (addr == ADDR_TUNING_MODE) ? tuning_mode_setting     :
    (addr == ADDR_STATUS)      ? status_word             : 16'h0000;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      rdata <= read_mux;
    end else begin
      rdata <= 16'h0000;
    end
  end

  // checks

  sequence s_bypass_rise;
    (switch_time_constant == '0) && primed && !wr && $rose(gain_after_active);
  endsequence

  sequence s_bypass_fall;
    (switch_time_constant == '0) && primed && !wr && $fell(gain_after_active);
  endsequence

  sequence s_ext_on_steady;
    switching_enabled && (sel_lo == SGS_COND_EXT) && (sel_hi == 4'h0)
      && ext_sync;
  endsequence

  model_gain_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RL3]
    (wr && addr == ADDR_MODEL_GAIN) ##1 (!wr || addr != ADDR_MODEL_GAIN) [*3]
      |-> (model_loop_gain == $past(wdata, 3)))
    else $error("model loop gain lost its written value");

  auto_tuning_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RL2]
    !switching_enabled |=> !gain_after_active)
    else $error("after set chosen outside manual tuning");

  ext_switch_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RL5]
    s_ext_on_steady |=> gain_after_active)
    else $error("external input on did not select after set");

  ext_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RL11]
    (sel_lo == SGS_COND_EXT) && (sel_hi == 4'h0) && !ext_sync |=> !gain_after_active)
    else $error("external input off kept after set");

  droop_level_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RL12]
    switching_enabled && (sel_lo == SGS_COND_DROOP) && (sel_hi == 4'h0)
      && (droop_pulses >= switch_threshold) |=> gain_after_active)
    else $error("droop above threshold did not select after set");

  speed_level_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RL6]
    (sel_lo == SGS_COND_SPEED) && (sel_hi == 4'h0)
      && (motor_speed < switch_threshold) |=> !gain_after_active)
    else $error("speed below threshold selected after set");

  after_gains_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RL8]
    s_bypass_rise ##1 ((switch_time_constant == '0) && gain_after_active && !wr)
      |-> (position_gain_out == after_set[CH_POS_GAIN])
       && (speed_gain_out == after_set[CH_SPD_GAIN])
       && (speed_integral_out == after_set[CH_SPD_INT]))
    else $error("after gains not applied");

  after_inertia_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RL9]
    s_bypass_rise ##1 ((switch_time_constant == '0) && gain_after_active && !wr)
      |-> (inertia_ratio_out == after_set[CH_INERTIA])
       && (vib_freq_out == after_set[CH_VIB_FREQ])
       && (resonance_freq_out == after_set[CH_RES_FREQ]))
    else $error("after inertia or frequencies not applied");

  return_before_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RL13]
    s_bypass_fall ##1 ((switch_time_constant == '0) && !gain_after_active && !wr)
      |-> (position_gain_out == before_set[CH_POS_GAIN])
       && (inertia_ratio_out == before_set[CH_INERTIA]))
    else $error("before set not restored");

  lag_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RL7]
    !lag_bypass && !step_pulse |=> $stable(position_gain_out))
    else $error("filtered value moved without a step");

  status_read_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RL1]
    rd && (addr == ADDR_STATUS) |=> (rdata[0] == $past(gain_after_active)))
    else $error("status read does not show active set");

endmodule : sgs_gain_switch
`default_nettype wire

// >>> rtl/sgs_pkg.sv
// sgs_pkg: constants shared by the gain set switcher and its lag filter
// assumes a 40 MHz control clock and 16-bit parameter words
package sgs_pkg;

  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned MS_PER_S   = 1000;
  // cycles in one millisecond of switching time constant
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  // filter moves 1/2^LAG_SHIFT of the gap per step, so 2^LAG_SHIFT steps per time constant
  localparam int unsigned LAG_SHIFT  = 6;
  localparam int unsigned STEP_CYC   = CYC_PER_MS >> LAG_SHIFT;

  localparam int unsigned DW     = 16;
  localparam int unsigned AW     = 5;
  localparam int unsigned N_CHAN = 6;

  // channel order inside the before and after sets
  localparam int unsigned CH_INERTIA  = 0;
  localparam int unsigned CH_POS_GAIN = 1;
  localparam int unsigned CH_SPD_GAIN = 2;
  localparam int unsigned CH_SPD_INT  = 3;
  localparam int unsigned CH_VIB_FREQ = 4;
  localparam int unsigned CH_RES_FREQ = 5;

  // register map (word addresses)
  localparam logic [AW-1:0] ADDR_BEFORE_BASE = 5'h00;
  localparam logic [AW-1:0] ADDR_AFTER_BASE  = 5'h08;
  localparam logic [AW-1:0] ADDR_MODEL_GAIN  = 5'h10;
  localparam logic [AW-1:0] ADDR_COND_SELECT = 5'h11;
  localparam logic [AW-1:0] ADDR_THRESHOLD   = 5'h12;
  localparam logic [AW-1:0] ADDR_TIME_CONST  = 5'h13;
  localparam logic [AW-1:0] ADDR_TUNING_MODE = 5'h14;
  localparam logic [AW-1:0] ADDR_STATUS      = 5'h15;

  // values after reset
  localparam logic [DW-1:0] RST_BEFORE [N_CHAN] = '{16'h0028, 16'h0078, 16'h0bb8,
                                                    16'h0014, 16'h0064, 16'h0064};
  localparam logic [DW-1:0] RST_AFTER  [N_CHAN] = '{16'h0064, 16'h0054, 16'h0fa0,
                                                    16'h0032, 16'h0064, 16'h0064};
  localparam logic [DW-1:0] RST_MODEL_GAIN  = 16'h0064;
  localparam logic [DW-1:0] RST_COND_SELECT = 16'h0000;
  localparam logic [DW-1:0] RST_THRESHOLD   = 16'h0000;
  localparam logic [DW-1:0] RST_TIME_CONST  = 16'h0064;
  localparam logic [DW-1:0] RST_TUNING_MODE = 16'h0001;

  // lowest digit of the selection setting
  typedef enum logic [3:0] {
    SGS_COND_NONE  = 4'h0,
    SGS_COND_EXT   = 4'h1,
    SGS_COND_CMD   = 4'h2,
    SGS_COND_DROOP = 4'h3,
    SGS_COND_SPEED = 4'h4
  } sgs_cond_e;

  // lowest digit of the tuning mode setting that selects manual adjustment
  localparam logic [3:0] TUNE_MANUAL = 4'h3;

endpackage : sgs_pkg

// >>> rtl/sgs_lag_filter.sv
// sgs_lag_filter: first-order delay on one parameter word
// assumes step pulses from the owner set the time constant; bypass tracks the target at once
`timescale 1ns/1ps
`default_nettype none

module sgs_lag_filter
  import sgs_pkg::*;
#(
  parameter int unsigned W = 16,
  parameter int unsigned F = 6
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // control
  input  wire logic         step,
  input  wire logic         bypass,
  // data
  input  wire logic [W-1:0] target,
  output logic      [W-1:0] value
);

  logic        [W+F-1:0] acc;
  logic signed [W+F:0]   diff;
  logic signed [W+F:0]   shifted;
  logic signed [W+F:0]   delta;
  logic        [W+F:0]   sum;

  // gap moved by 1/2^F per step, never less than one fraction unit so it settles exactly
  assign diff    = $signed({1'b0, target, {F{1'b0}}}) - $signed({1'b0, acc});
  assign shifted = diff >>> F;
  assign delta   = (shifted != '0) ? shifted :
                   (diff[W+F] ? {(W+F+1){1'b1}} :
                   ((diff != '0) ? {{(W+F){1'b0}}, 1'b1} : '0));
  assign sum     = {1'b0, acc} + delta;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      acc <= '0;
    end else if (bypass) begin
      acc <= {target, {F{1'b0}}};
    end else if (step) begin
      acc <= sum[W+F-1:0]; // see [RL7]
    end
  end

  assign value = acc[W+F-1:F];

  lag_toward_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RL7]
    (step && !bypass && (target > value) ##1 (target == $past(target)))
      |-> (value >= $past(value)) && (value <= target))
    else $error("lag filter moved away from its target");

endmodule : sgs_lag_filter
`default_nettype wire

// >>> test/sgs_gain_switch_tb.sv
// sgs_gain_switch_tb: self-checking bench for the gain set switcher
// assumes sgs_pkg reset values and a filter step of one cycle per millisecond setting
`timescale 1ns/1ps
`default_nettype none

module sgs_gain_switch_tb;
  import sgs_pkg::*;

  logic          clk_sys;
  logic          resetn;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          wr;
  logic          rd;
  logic [DW-1:0] rdata;
  logic          ext_in;
  logic [DW-1:0] cmd_q;
  logic [DW-1:0] droop_q;
  logic [DW-1:0] speed_q;
  logic [DW-1:0] model_q;
  logic [DW-1:0] outv [N_CHAN];
  logic          gact;
  logic [DW-1:0] model_exp;
  int            mismatches;
  int            check_count;

  sgs_gain_switch #(.STEP_CYCLES(1)) sgs_gain_switch_inst (
    .clk_sys                    (clk_sys),
    .resetn                     (resetn),
    .addr                       (addr),
    .wdata                      (wdata),
    .wr                         (wr),
    .rd                         (rd),
    .rdata                      (rdata),
    .external_gain_switch_input (ext_in),
    .command_freq               (cmd_q),
    .droop_pulses               (droop_q),
    .motor_speed                (speed_q),
    .model_loop_gain            (model_q),
    .inertia_ratio_out          (outv[0]),
    .position_gain_out          (outv[1]),
    .speed_gain_out             (outv[2]),
    .speed_integral_out         (outv[3]),
    .vib_freq_out               (outv[4]),
    .resonance_freq_out         (outv[5]),
    .gain_after_active          (gact)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check_word(string what, logic [DW-1:0] exp, logic [DW-1:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(string what, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic write_reg(logic [AW-1:0] a, logic [DW-1:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic read_check(string what, logic [AW-1:0] a, logic [DW-1:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1;
    check_word(what, exp, rdata);
  endtask

  task automatic set_q(logic [DW-1:0] c, logic [DW-1:0] d, logic [DW-1:0] s);
    @(posedge clk_sys);
    cmd_q   <= c;
    droop_q <= d;
    speed_q <= s;
  endtask

  // with a zero time constant, outputs follow the selected set one edge after the selection flag
  task automatic wait_act(logic exp);
    for (int n = 0; n < 10 && gact !== exp; n++) begin
      @(posedge clk_sys);
      #1;
    end
    check_bit("gain_after_active", exp, gact);
    @(posedge clk_sys);
    #1;
  endtask

  function automatic logic set_eq(logic after_set);
    logic eq;
    eq = 1'b1;
    for (int i = 0; i < N_CHAN; i++) begin
      if (outv[i] !== (after_set ? RST_AFTER[i] : RST_BEFORE[i])) eq = 1'b0;
    end
    return eq;
  endfunction

  task automatic check_set(logic after_set);
    for (int i = 0; i < N_CHAN; i++) begin
      check_word($sformatf("out%0d", i), after_set ? RST_AFTER[i] : RST_BEFORE[i], outv[i]);
    end
    check_word("model_loop_gain", model_exp, model_q);
  endtask

  task automatic t_reset();
    for (int i = 0; i < N_CHAN; i++) begin
      read_check("before reg", ADDR_BEFORE_BASE + 5'(i), RST_BEFORE[i]);
      read_check("after reg", ADDR_AFTER_BASE + 5'(i), RST_AFTER[i]);
    end
    read_check("model reg", ADDR_MODEL_GAIN, RST_MODEL_GAIN);
    read_check("select reg", ADDR_COND_SELECT, RST_COND_SELECT);
    read_check("threshold reg", ADDR_THRESHOLD, RST_THRESHOLD);
    read_check("time const reg", ADDR_TIME_CONST, RST_TIME_CONST);
    read_check("tuning reg", ADDR_TUNING_MODE, RST_TUNING_MODE);
    read_check("status reg", ADDR_STATUS, 16'h0000);
    read_check("unmapped", 5'h1f, 16'h0000);
    check_set(1'b0);
  endtask

  task automatic t_auto_then_manual();
    write_reg(ADDR_TIME_CONST, 16'h0000);
    write_reg(ADDR_THRESHOLD, 16'h0032);
    write_reg(ADDR_COND_SELECT, 16'h0003);
    set_q(16'h0000, 16'h003c, 16'h0000);
    repeat (10) @(posedge clk_sys);
    #1;
    check_bit("locked in auto", 1'b0, gact);
    check_set(1'b0);
    write_reg(ADDR_TUNING_MODE, {12'h000, TUNE_MANUAL});
    wait_act(1'b1);
    check_set(1'b1);
    set_q(16'h0000, 16'h000a, 16'h0000);
    wait_act(1'b0);
    check_set(1'b0);
  endtask

  task automatic cond_case(logic [DW-1:0] sel, logic [DW-1:0] c, logic [DW-1:0] d,
                           logic [DW-1:0] s, logic exp);
    write_reg(ADDR_COND_SELECT, sel);
    set_q(c, d, s);
    wait_act(exp);
    check_set(exp);
  endtask

  task automatic t_conditions();
    cond_case(16'h0002, 16'h0032, 16'h0000, 16'h0000, 1'b1);
    cond_case(16'h0002, 16'h0031, 16'h0000, 16'h0000, 1'b0);
    cond_case(16'h0004, 16'h0000, 16'h0000, 16'h0032, 1'b1);
    cond_case(16'h0004, 16'h0000, 16'h0000, 16'h0031, 1'b0);
    cond_case(16'h0013, 16'h0000, 16'h000a, 16'h0000, 1'b1);
    cond_case(16'h0000, 16'h0032, 16'h0032, 16'h0032, 1'b0);
  endtask

  task automatic t_external();
    write_reg(ADDR_MODEL_GAIN, 16'h0050);
    model_exp = 16'h0050;
    write_reg(ADDR_COND_SELECT, 16'h0001);
    @(posedge clk_sys);
    ext_in <= 1'b1;
    wait_act(1'b1);
    check_set(1'b1);
    // status is read-only: the write must leave it untouched
    write_reg(ADDR_STATUS, 16'h0000);
    read_check("status ext on", ADDR_STATUS, 16'h0007);
    read_check("model written", ADDR_MODEL_GAIN, 16'h0050);
    @(posedge clk_sys);
    ext_in <= 1'b0;
    wait_act(1'b0);
    check_set(1'b0);
  endtask

  task automatic settle(logic after_set);
    for (int n = 0; n < 3000 && !set_eq(after_set); n++) begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic t_filter();
    write_reg(ADDR_TIME_CONST, 16'h0001);
    write_reg(ADDR_COND_SELECT, 16'h0003);
    set_q(16'h0000, 16'h003c, 16'h0000);
    wait_act(1'b1);
    check_bit("lag rising", 1'b1,
              (outv[2] > RST_BEFORE[2]) && (outv[2] < RST_AFTER[2]));
    settle(1'b1);
    check_set(1'b1);
    set_q(16'h0000, 16'h000a, 16'h0000);
    wait_act(1'b0);
    check_bit("lag falling", 1'b1,
              (outv[2] > RST_BEFORE[2]) && (outv[2] < RST_AFTER[2]));
    settle(1'b0);
    check_set(1'b0);
  endtask

  // software keeps the after inertia equal to the before one when the load is unchanged
  task automatic t_same_inertia();
    write_reg(ADDR_TIME_CONST, 16'h0000);
    write_reg(ADDR_AFTER_BASE + 5'(CH_INERTIA), RST_BEFORE[CH_INERTIA]);
    set_q(16'h0000, 16'h003c, 16'h0000);
    wait_act(1'b1);
    check_word("inertia kept", RST_BEFORE[CH_INERTIA], outv[CH_INERTIA]);
    check_word("pos gain after", RST_AFTER[CH_POS_GAIN], outv[CH_POS_GAIN]);
    set_q(16'h0000, 16'h000a, 16'h0000);
    wait_act(1'b0);
    check_word("inertia back", RST_BEFORE[CH_INERTIA], outv[CH_INERTIA]);
    check_word("pos gain back", RST_BEFORE[CH_POS_GAIN], outv[CH_POS_GAIN]);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    conclude();
  end

  initial begin
    resetn  = 1'b0;
    addr    = '0;
    wdata   = '0;
    wr      = 1'b0;
    rd      = 1'b0;
    ext_in  = 1'b0;
    cmd_q   = '0;
    droop_q = '0;
    speed_q = '0;
    model_exp = RST_MODEL_GAIN;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    t_reset();
    t_auto_then_manual();
    t_conditions();
    t_external();
    t_filter();
    t_same_inertia();
    conclude();
  end

endmodule // sgs_gain_switch_tb

`default_nettype wire
